// file: logic/ima_core.sv
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - an operation whose condition is false writes neither the destination nor the flags.
// - the plain multiply writes the product of the two multiplicands to the destination.
// - the addend field is ignored for a plain multiply and the producer should encode it as zero.
// - the accumulate variant adds the addend to the product and writes that sum.
// - only the low 32 bits are produced, which are the same for signed and unsigned operands.
// - flags change only when the flag-update bit is set.
// - on a flag update negative takes bit 31 of the result.
// - on a flag update zero is set exactly when the result is zero.
// - on a flag update carry is meaningless and overflow stays unchanged.
// - an operation takes no fewer than 3 and no more than 6 cycles.
// - base latency is 6 with no extra cost for accumulate, shortened by 0 to 3 for early exit.
module ima_core
   import ima_pkg::*;
(
   input  wire logic                    clk_in,
   input  wire logic                    sys_rst_in,
   // issue port from the decoder
   input  wire logic                    start_in,
   input  wire logic                    cond_pass_in,
   input  wire logic                    accumulate_in,
   input  wire logic                    set_flags_in,
   input  wire logic [IMA_REGNUM_W-1:0] dest_num_in,
   input  wire logic [IMA_DATA_W-1:0]   mult_src_a_in,
   input  wire logic [IMA_DATA_W-1:0]   mult_src_b_in,
   input  wire logic [IMA_DATA_W-1:0]   addend_reg_in,
   input  wire logic                    flag_v_in,
   // plain software port
   input  wire logic [3:0]              sw_addr_in,
   input  wire logic [31:0]             sw_wdata_in,
   input  wire logic                    sw_wr_in,
   input  wire logic                    sw_rd_in,
   output logic      [31:0]             sw_rdata_out,
   // result to register file and flag logic
   output logic                         busy_out,
   output logic                         done_out,
   output logic                         wr_en_out,
   output logic      [IMA_REGNUM_W-1:0] wr_num_out,
   output logic      [IMA_DATA_W-1:0]   result_out,
   output logic                         flags_wr_out,
   output logic                         flag_n_out,
   output logic                         flag_z_out,
   output logic                         flag_c_out,
   output logic                         flag_v_out
);
   localparam logic [2:0] BASE_CNT = 3'(IMA_BASE_CYCLES);

   ima_state_e                  state_reg,    state_next;
   logic [2:0]                  cnt_reg,      cnt_next;
   logic [IMA_DATA_W-1:0]       acc_reg,      acc_next;
   logic                        sf_reg,       sf_next;
   logic                        vsave_reg,    vsave_next;
   logic [IMA_REGNUM_W-1:0]     dnum_reg,     dnum_next;
   logic                        early_en_reg, early_en_next;
   logic [IMA_DATA_W-1:0]       last_res_reg, last_res_next;
   logic [2:0]                  last_cnt_reg, last_cnt_next;
   logic [31:0]                 rdata_next;
   logic                        busy_next,    done_next,  wr_en_next, flags_wr_next;
   logic [IMA_REGNUM_W-1:0]     wr_num_next;
   logic [IMA_DATA_W-1:0]       result_next;
   logic                        n_next,       z_next,     c_next,     v_next;
   logic [1:0]                  save;
   logic [IMA_DATA_W-1:0]       product;
   logic                        issue;

   ima_sig_width #(
      .W        (IMA_DATA_W)
   ) u_sig (
      .value_in (mult_src_b_in),
      .save_out (save)
   );

   // unsigned product truncated; low word is sign-agnostic
   assign product = IMA_DATA_W'(mult_src_a_in * mult_src_b_in);
   // a false condition never leaves idle, so nothing is written
   assign issue   = start_in & cond_pass_in & (state_reg == IMA_IDLE);

   // sequencer: the result is computed at issue and held, so the
   // countdown models latency only; cheaper than an iterative array
   always_comb begin
      state_next    = state_reg;
      cnt_next      = cnt_reg;
      acc_next      = acc_reg;
      sf_next       = sf_reg;
      vsave_next    = vsave_reg;
      dnum_next     = dnum_reg;
      last_res_next = last_res_reg;
      last_cnt_next = last_cnt_reg;
      busy_next     = 1'b0;
      done_next     = 1'b0;
      wr_en_next    = 1'b0;
      flags_wr_next = 1'b0;
      wr_num_next   = wr_num_out;
      result_next   = result_out;
      n_next        = flag_n_out;
      z_next        = flag_z_out;
      c_next        = flag_c_out;
      v_next        = flag_v_out;
      unique case (state_reg)
         IMA_IDLE: begin
            if (issue) begin
               // addend is simply not used on the plain form
               acc_next   = accumulate_in ? product + addend_reg_in : product;
               sf_next    = set_flags_in;
               vsave_next = flag_v_in;
               dnum_next  = dest_num_in;
               // 6 cycles total including the done cycle, less the early-exit saving when enabled; same for accumulate
               cnt_next   = BASE_CNT - 3'h2 - (early_en_reg ? {1'b0, save} : 3'h0);
               last_cnt_next = BASE_CNT - (early_en_reg ? {1'b0, save} : 3'h0);
               busy_next  = 1'b1;
               state_next = IMA_BUSY;
            end
         end
         IMA_BUSY: begin
            busy_next = 1'b1;
            if (cnt_reg == IMA_CNT_RST) begin
               state_next = IMA_DONE;
            end else begin
               cnt_next = cnt_reg - 3'h1;
            end
         end
         IMA_DONE: begin
            // busy drops together with the write so dependants stall until here
            done_next     = 1'b1;
            wr_en_next    = 1'b1;
            wr_num_next   = dnum_reg;
            result_next   = acc_reg;
            last_res_next = acc_reg;
            if (sf_reg) begin
               flags_wr_next = 1'b1;
               n_next = acc_reg[IMA_DATA_W-1];
               z_next = (acc_reg == IMA_RESULT_RST);
               c_next = 1'b0;
               v_next = vsave_reg;
            end
            state_next = IMA_IDLE;
         end
         // the unused fourth code falls back to idle rather than hanging
         default: state_next = IMA_IDLE;
      endcase
   end

   // software port: control is writable, the rest read-only
   always_comb begin
      early_en_next = early_en_reg;
      rdata_next    = 32'h0000_0000;
      if (sw_wr_in && sw_addr_in == IMA_ADDR_CTRL)
         early_en_next = sw_wdata_in[IMA_CTRL_EARLY_B];
      if (sw_rd_in) begin
         unique case (sw_addr_in)
            IMA_ADDR_CTRL:   rdata_next = {31'h0, early_en_reg};
            IMA_ADDR_STATUS: rdata_next = {30'h0, state_reg == IMA_DONE, busy_out};
            IMA_ADDR_RESULT: rdata_next = last_res_reg;
            IMA_ADDR_COUNT:  rdata_next = {29'h0, last_cnt_reg};
            default:         rdata_next = 32'h0000_0000; // unmapped reads zero
         endcase
      end
   end

   // all state and every output registered here
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_reg    <= IMA_IDLE;
         cnt_reg      <= IMA_CNT_RST;
         acc_reg      <= IMA_RESULT_RST;
         sf_reg       <= 1'b0;
         vsave_reg    <= 1'b0;
         dnum_reg     <= '0;
         early_en_reg <= 1'b1;
         last_res_reg <= IMA_RESULT_RST;
         last_cnt_reg <= IMA_CNT_RST;
         sw_rdata_out <= 32'h0000_0000;
         busy_out     <= 1'b0;
         done_out     <= 1'b0;
         wr_en_out    <= 1'b0;
         wr_num_out   <= '0;
         result_out   <= IMA_RESULT_RST;
         flags_wr_out <= 1'b0;
         flag_n_out   <= 1'b0;
         flag_z_out   <= 1'b0;
         flag_c_out   <= 1'b0;
         flag_v_out   <= 1'b0;
      end else begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         acc_reg      <= acc_next;
         sf_reg       <= sf_next;
         vsave_reg    <= vsave_next;
         dnum_reg     <= dnum_next;
         early_en_reg <= early_en_next;
         last_res_reg <= last_res_next;
         last_cnt_reg <= last_cnt_next;
         sw_rdata_out <= rdata_next;
         busy_out     <= busy_next;
         done_out     <= done_next;
         wr_en_out    <= wr_en_next;
         wr_num_out   <= wr_num_next;
         result_out   <= result_next;
         flags_wr_out <= flags_wr_next;
         flag_n_out   <= n_next;
         flag_z_out   <= z_next;
         flag_c_out   <= c_next;
         flag_v_out   <= v_next;
      end
   end
endmodule

// file: logic/ima_pkg.sv
package ima_pkg;
   localparam int          IMA_DATA_W       = 32;
   localparam int          IMA_REGNUM_W     = 4;
   // latency figures in core cycles
   localparam int          IMA_BASE_CYCLES  = 6;
   localparam int          IMA_MAX_EARLY    = 3;
   localparam int          IMA_MIN_CYCLES   = IMA_BASE_CYCLES - IMA_MAX_EARLY;
   localparam logic [2:0]  IMA_CNT_RST      = 3'h0;
   localparam logic [31:0] IMA_RESULT_RST   = 32'h0000_0000;
   // register-number field of the program counter
   localparam logic [3:0]  IMA_PC_REGNUM    = 4'hf;
   // early-exit widths of the second multiplicand, in bits
   localparam int          IMA_SIG_W1       = 8;
   localparam int          IMA_SIG_W2       = 16;
   localparam int          IMA_SIG_W3       = 24;
   // register map of the plain software port
   localparam logic [3:0]  IMA_ADDR_CTRL    = 4'h0;
   localparam logic [3:0]  IMA_ADDR_STATUS  = 4'h4;
   localparam logic [3:0]  IMA_ADDR_RESULT  = 4'h8;
   localparam logic [3:0]  IMA_ADDR_COUNT   = 4'hc;
   localparam int          IMA_CTRL_EARLY_B = 0;
   typedef enum logic [1:0] {IMA_IDLE, IMA_BUSY, IMA_DONE} ima_state_e;
endpackage

// file: logic/ima_sig_width.sv
`timescale 1ns/1ps
// counts how many cycles early termination may save for one multiplicand
module ima_sig_width
   import ima_pkg::*;
#(
   parameter int W = 32
) (
   input  wire logic [W-1:0] value_in,
   output logic      [1:0]   save_out
);
   // a byte group is insignificant when it is pure sign extension
   function automatic logic sign_ext(input logic [W-1:0] v, input int n);
      logic ones;
      logic zeros;
      ones  = 1'b1;
      zeros = 1'b1;
      for (int i = n - 1; i < W; i++) begin
         ones  = ones & v[i];
         zeros = zeros & ~v[i];
      end
      return ones | zeros;
   endfunction

   always_comb begin
      if (sign_ext(value_in, IMA_SIG_W1))
         save_out = 2'h3;
      else if (sign_ext(value_in, IMA_SIG_W2))
         save_out = 2'h2;
      else if (sign_ext(value_in, IMA_SIG_W3))
         save_out = 2'h1;
      else
         save_out = 2'h0;
   end
endmodule

// file: test/ima_core_asserts.sv
`timescale 1ns/1ps
// watches issue and write-back timing of the multiply unit
module ima_core_asserts
   import ima_pkg::*;
(
   input wire logic                  clk_in,
   input wire logic                  sys_rst_in,
   input wire logic                  start_in,
   input wire logic                  cond_pass_in,
   input wire logic                  busy_out,
   input wire logic                  done_out,
   input wire logic                  wr_en_out,
   input wire logic [IMA_DATA_W-1:0] result_out,
   input wire logic                  flags_wr_out,
   input wire logic                  flag_n_out,
   input wire logic                  flag_z_out,
   input wire logic                  flag_c_out,
   input wire logic                  flag_v_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   logic take;
   // an issue counts only while idle
   assign take = start_in && cond_pass_in && !busy_out;
   AST_BUSY_ON: assert property (take |=> busy_out) else $error("busy missing");
   // done is registered, so it is sampled one edge after the last counted cycle
   AST_LATENCY: assert property (take |=> !done_out [*3] ##[1:4] done_out) else $error("latency");
   AST_BUSY_HOLD: assert property (busy_out |=> busy_out || done_out) else $error("busy dropped");
   AST_NO_EXEC: assert property (start_in && !cond_pass_in && !busy_out && !done_out |=> !busy_out && !done_out)
      else $error("false condition ran");
   AST_WR_PAIR: assert property (wr_en_out == done_out) else $error("write strobe");
   AST_FLAG_WR: assert property (flags_wr_out |-> done_out) else $error("flag write alone");
   AST_NEG: assert property (flags_wr_out |-> flag_n_out == result_out[31]) else $error("negative flag");
   AST_ZERO: assert property (flags_wr_out |-> flag_z_out == (result_out == 32'h0)) else $error("zero flag");
   // reset clears flags, so the edge after it is excused
   AST_HOLD: assert property (!flags_wr_out && !$past(sys_rst_in) |-> $stable({flag_n_out, flag_z_out, flag_c_out,
      flag_v_out})) else $error("flags moved");
   COV_FAST: cover property (take ##4 done_out);
   COV_SLOW: cover property (take ##7 done_out);
   COV_ZERO: cover property (flags_wr_out && flag_z_out);
endmodule
bind ima_core ima_core_asserts i_ima_core_asserts (.*);

// file: test/ima_rf_model.sv
`timescale 1ns/1ps
// register-file sink for the write-back port
module ima_rf_model
   import ima_pkg::*;
(
   input wire logic                    clk_in,
   input wire logic                    wr_en_in,
   input wire logic [IMA_REGNUM_W-1:0] wr_num_in,
   input wire logic [IMA_DATA_W-1:0]   result_in
);
   logic [IMA_DATA_W-1:0] regs_reg [16];
   // only the completion pulse writes, so half-done results never land
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         regs_reg[wr_num_in] <= result_in;
      end
   end
endmodule

// file: test/integer_multiply_accumulate_test.sv
`timescale 1ns/1ps
module integer_multiply_accumulate_test;
   import ima_pkg::*;
   typedef struct {logic acc; logic s; logic cnd; logic v; logic [31:0] a, b, c; int lat;} ima_row_s;
   logic clk_in, sys_rst_in, start_in, cond_pass_in, accumulate_in, set_flags_in, flag_v_in, sw_wr_in, sw_rd_in;
   logic [3:0] dest_num_in, sw_addr_in, wr_num_out;
   logic [31:0] mult_src_a_in, mult_src_b_in, addend_reg_in, sw_wdata_in, sw_rdata_out, result_out, last_res;
   logic busy_out, done_out, wr_en_out, flags_wr_out, flag_n_out, flag_z_out, flag_c_out, flag_v_out;
   logic [2:0] exp_f;
   int err_total, samples_checked;
   // acc s cnd v a b c latency
   ima_row_s rows [6] = '{
      '{0, 1, 1, 1, 32'hffff_fff6, 32'h0000_0014, 32'h0, 3},
      '{1, 0, 1, 0, 32'h3, 32'h0000_4000, 32'h5, 4},
      '{0, 1, 1, 0, 32'h0001_0000, 32'h0001_0000, 32'hdead, 5},
      '{1, 1, 1, 1, 32'h3, 32'h8000_0000, 32'h1, 6},
      '{0, 1, 0, 0, 32'h5, 32'h5, 32'h0, 0},
      '{1, 1, 1, 0, 32'hffff_ffff, 32'hffff_ff80, 32'h7, 3}};
   ima_core i_ima_core (.*);
   ima_rf_model i_ima_rf_model (.clk_in(clk_in), .wr_en_in(wr_en_out), .wr_num_in(wr_num_out), .result_in(result_out));
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic sw_wr(logic [3:0] ad, logic [31:0] d);
      @(posedge clk_in);
      sw_addr_in <= ad;
      sw_wdata_in <= d;
      sw_wr_in <= 1'h1;
      @(posedge clk_in);
      sw_wr_in <= 1'h0;
   endtask
   task automatic sw_rd(logic [3:0] ad, logic [31:0] exp, string nm);
      @(posedge clk_in);
      sw_addr_in <= ad;
      sw_rd_in <= 1'h1;
      @(posedge clk_in);
      sw_rd_in <= 1'h0;
      @(negedge clk_in);
      chk(nm, sw_rdata_out, exp);
   endtask
   // issue at a rising edge, then follow the result back at falling edges
   task automatic run_op(ima_row_s r);
      logic [31:0] res;
      int n;
      res = r.a * r.b + (r.acc ? r.c : 32'h0);
      // whole cycles from the issue edge to the done pulse
      n = 0;
      @(posedge clk_in);
      {start_in, cond_pass_in, accumulate_in, set_flags_in, flag_v_in} <= {1'h1, r.cnd, r.acc, r.s, r.v};
      {mult_src_a_in, mult_src_b_in, addend_reg_in} <= {r.a, r.b, r.c};
      dest_num_in <= 4'h3;
      @(posedge clk_in);
      start_in <= 1'h0;
      flag_v_in <= ~r.v;
      @(negedge clk_in);
      while (done_out !== 1'h1 && n < 10) begin
         @(negedge clk_in);
         n++;
      end
      if (!r.cnd) begin
         chk("skipped op", 32'(n), 32'ha);
         chk("kept result", result_out, last_res);
         return;
      end
      if (n >= 10) begin
         err_total++;
         end_sim();
      end
      chk("latency", 32'(n), 32'(r.lat));
      chk("result", result_out, res);
      chk("write", 32'({wr_en_out, flags_wr_out, wr_num_out}), 32'({1'h1, r.s, 4'h3}));
      if (r.s) exp_f = {res[31], res == 32'h0, r.v};
      chk("flags", 32'({flag_n_out, flag_z_out, flag_v_out}), 32'(exp_f));
      last_res = res;
   endtask
   initial begin
      clk_in = 1'h0;
      forever #20 clk_in = ~clk_in;
   end
   initial begin
      {sys_rst_in, start_in, cond_pass_in, accumulate_in, set_flags_in, flag_v_in, sw_wr_in, sw_rd_in} = 8'h80;
      {dest_num_in, sw_addr_in, mult_src_a_in, mult_src_b_in, addend_reg_in, sw_wdata_in} = '0;
      {err_total, samples_checked, exp_f, last_res} = '0;
      repeat (16) @(posedge clk_in);
      sys_rst_in <= 1'h0;
      sw_rd(IMA_ADDR_CTRL, 32'h1, "ctrl reset");
      foreach (rows[i]) run_op(rows[i]);
      // the register file takes the write at the edge after the done pulse
      @(negedge clk_in);
      chk("reg file", i_ima_rf_model.regs_reg[3], last_res);
      // early exit off: even a tiny multiplier takes the full count
      sw_wr(IMA_ADDR_CTRL, 32'h0);
      run_op('{0, 0, 1, 0, 32'h2, 32'h3, 32'h0, 6});
      sw_rd(IMA_ADDR_COUNT, 32'h6, "count");
      sw_rd(IMA_ADDR_RESULT, last_res, "last result");
      sw_rd(4'h2, 32'h0, "unmapped");
      // reset in mid-operation must abort it and restore the control register
      @(posedge clk_in);
      {start_in, cond_pass_in, mult_src_b_in} <= {1'h1, 1'h1, 32'h8000_0000};
      @(posedge clk_in);
      start_in <= 1'h0;
      sw_rd(IMA_ADDR_STATUS, 32'h1, "status busy");
      @(posedge clk_in);
      sys_rst_in <= 1'h1;
      @(posedge clk_in);
      sys_rst_in <= 1'h0;
      @(negedge clk_in);
      chk("after reset", result_out, 32'h0);
      chk("after reset strobes", 32'({busy_out, done_out, wr_en_out, flags_wr_out}), 32'h0);
      // the aborted operation must never reach write-back
      repeat (8) begin
         @(negedge clk_in);
         chk("aborted op", 32'(done_out), 32'h0);
      end
      sw_rd(IMA_ADDR_CTRL, 32'h1, "ctrl again");
      sw_rd(IMA_ADDR_RESULT, 32'h0, "result after reset");
      end_sim();
   end
endmodule
